// file: dv/perf_event_counter_unit_bench.sv
// Self-checking bench for the event counter unit
`timescale 1ns/1ps
`default_nettype none
module perf_event_counter_unit_bench;
  logic        core_clk, rst, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [47:0] ev_pulse;
  logic [2:0]  ev_wq, ev_tc;
  logic [63:0] x;
  logic [32:0] want;
  logic [32:0] exp_q[$];
  logic [7:0]  evc[6] = '{8'h0F, 8'hFF, 8'h3F, 8'hFF, 8'h07, 8'h00};
  wire logic [31:0] prdata;
  wire logic        pready, pslverr;
  int fail_count, num_checks, cyc;
  int e[4];

  pmu_event_counter dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ev_pulse(ev_pulse), .ev_wq(ev_wq), .ev_tc(ev_tc));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [11:0] ca(input int n, input int s);
    return 12'(64 + 16 * n + 4 * s);
  endfunction

  function automatic logic [31:0] cf(input logic [3:0] c, input logic [7:0] m, input logic g);
    return {8'h00, m, 4'h0, c, 6'h00, g, 1'b1};
  endfunction

  // Request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic err = 1'b0);
    exp_q.push_back({err, d});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic pl(input logic [47:0] p);
    @(posedge core_clk);
    ev_pulse <= p;
    @(posedge core_clk);
    ev_pulse <= '0;
  endtask

  // Read results checked against the oldest note
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      want = exp_q.pop_front();
      num_checks++;
      if ({pslverr, prdata} !== want) begin
        fail_count++;
        $display("unexpected at %0t: addr %h got %h want %h", $time, paddr, {pslverr, prdata}, want);
      end
    end
  end

  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    ev_pulse = 48'h0000_0000_0000;
    {ev_wq, ev_tc} = 6'h00;
    cyc = 0;
    fail_count = 0;
    num_checks = 0;
    e = '{0, 0, 0, 0};
    void'($urandom(32'h411e));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(12'h000, 32'h000F_2004);
    rd(12'h004, 32'h0000_0000);
    for (int c = 0; c < 6; c++) rd(12'(16 + 4 * c), {24'h0, evc[c]});
    for (int n = 0; n < 4; n++) rd(12'(128 + 4 * n), n < 2 ? 32'h3F20 : 32'h3F10);
    rd(12'h0FC, 32'h0000_0000, 1'b1);
    $display("capability test done");
    apb(1'b1, ca(0, 1), 32'h0000_0305);
    apb(1'b1, ca(0, 0), cf(4'h1, 8'hFF, 1'b0));
    apb(1'b1, ca(0, 1), 32'h0000_0000);
    apb(1'b1, ca(1, 0), cf(4'h1, 8'hFF, 1'b0));
    apb(1'b1, ca(1, 0), cf(4'h0, 8'hFF, 1'b0));
    apb(1'b1, ca(2, 0), cf(4'h0, 8'hFF, 1'b0));
    apb(1'b1, ca(3, 0), cf(4'h5, 8'hFF, 1'b0));
    for (int i = 0; i < 200; i++) begin
      @(posedge core_clk);
      x = {$urandom(), $urandom()};
      ev_pulse <= x[47:0];
      ev_wq <= x[50:48];
      ev_tc <= x[53:51];
      e[1] += $countones(x[15:8]);
      e[2] += $countones(x[7:0] & 8'h0F);
      if ((x[50:48] == 0 || x[50:48] == 2) && x[53:51] < 2) e[0] += $countones(x[15:8]);
    end
    @(posedge core_clk);
    ev_pulse <= '0;
    rd(ca(1, 0), cf(4'h1, 8'hFF, 1'b0));
    for (int n = 0; n < 4; n++) rd(ca(n, 2), 32'(e[n]));
    $display("counting test done");
    apb(1'b1, 12'h004, 32'h0000_0003);
    rd(ca(1, 0), 32'h0000_0000);
    rd(ca(1, 2), 32'h0000_0000);
    apb(1'b1, ca(3, 2), 32'hFFFF_FFFF);
    apb(1'b1, ca(2, 2), 32'hFFFF_FFFF);
    apb(1'b1, ca(2, 3), 32'hFFFF_FFFF);
    rd(ca(2, 2), 32'h0000_FFFF);
    rd(ca(2, 3), 32'h0000_0000);
    apb(1'b1, ca(3, 0), cf(4'h1, 8'h01, 1'b0));
    apb(1'b1, ca(2, 0), cf(4'h1, 8'h02, 1'b1));
    repeat (2) pl(48'h0000_0000_0100);
    rd(ca(3, 2), 32'h0000_0001);
    rd(12'h008, 32'h0000_0008);
    pl(48'h0000_0000_0200);
    pl(48'h0000_0000_0300);
    rd(12'h008, 32'h0000_000C);
    rd(12'h00C, 32'h0000_000F);
    rd(ca(3, 2), 32'h0000_0001);
    rd(ca(2, 2), 32'h0000_0000);
    apb(1'b1, 12'h00C, 32'h0000_0000);
    pl(48'h0000_0000_0100);
    rd(ca(3, 2), 32'h0000_0002);
    apb(1'b1, ca(3, 2), 32'h0000_0005);
    rd(ca(3, 2), 32'h0000_0005);
    apb(1'b1, 12'h00C, 32'h0000_0008);
    pl(48'h0000_0000_0100);
    rd(ca(3, 2), 32'h0000_0005);
    apb(1'b1, 12'h008, 32'h0000_000C);
    rd(12'h008, 32'h0000_0000);
    apb(1'b1, 12'h004, 32'h0000_0001);
    rd(12'h00C, 32'h0000_0000);
    rd(ca(3, 0), 32'h0000_0000);
    pl(48'h0000_0000_0100);
    rd(ca(3, 2), 32'h0000_0005);
    apb(1'b1, 12'h004, 32'h0000_0002);
    rd(ca(3, 2), 32'h0000_0000);
    $display("overflow test done");
    conclude();
  end
endmodule // perf_event_counter_unit_bench
`default_nettype wire

// file: dv/pmu_event_counter_properties.sv
// Port checks for the event counter unit
`timescale 1ns/1ps
`default_nettype none
module pmu_event_counter_properties #(
  parameter MON_PRESENT = 1,
  parameter WR_WHILE_EN = 1
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  localparam logic [31:0] WWE = WR_WHILE_EN ? 32'h0001_0000 : 32'h0000_0000;
  localparam logic [31:0] CAP = MON_PRESENT ? (32'h000E_2004 | WWE) : 32'h0000_0000;
  wire logic rd = psel && penable && !pwrite;
  wire logic hi = paddr[11:6] == 6'h01 && paddr[3:0] == 4'hC;
  a_cap_word: assert property (rd && paddr == 12'h000 |-> prdata == CAP)
    else $error("capability word wrong");
  a_evcap_xlate: assert property (rd && paddr == 12'h018 |-> prdata == 32'h0000_003F)
    else $error("event capability wrong");
  a_evcap_none: assert property (rd && paddr == 12'h024 |-> prdata == 32'h0000_0000)
    else $error("empty category not zero");
  a_ccap_wide: assert property (rd && paddr == 12'h080 |-> prdata == 32'h0000_3F20)
    else $error("wide counter capability wrong");
  a_ccap_narrow: assert property (rd && paddr == 12'h088 |-> prdata == 32'h0000_3F10)
    else $error("narrow counter capability wrong");
  a_rstctl_zero: assert property (rd && paddr == 12'h004 |-> prdata == 32'h0000_0000)
    else $error("reset control not zero");
  a_hi_zero: assert property (rd && hi |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("high value word not zero");
  a_hi_noerr: assert property (psel && penable && pwrite && hi |-> pready && !pslverr)
    else $error("high word write errored");
  a_rdata_hold: assert property (psel && penable |=> $stable(prdata))
    else $error("read data moved");
endmodule // pmu_event_counter_properties

bind pmu_event_counter pmu_event_counter_properties #(
  .MON_PRESENT(MON_PRESENT),
  .WR_WHILE_EN(WR_WHILE_EN)
) u_props (
  .core_clk(core_clk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr)
);
`default_nettype wire

// file: shared/pmu_regs.vh
// Register map, field positions, reset values and sizes of the event counter unit
`ifndef PMU_REGS_VH
`define PMU_REGS_VH

// Byte offsets on the APB register bus
`define PMU_OFF_CAP        12'h000
`define PMU_OFF_RST        12'h004
`define PMU_OFF_OVF        12'h008
`define PMU_OFF_FRZ        12'h00C
`define PMU_OFF_EVCAP      12'h010
`define PMU_OFF_CNT_BASE   12'h040
`define PMU_CNT_STRIDE     12'h010
`define PMU_OFF_CCAP_BASE  12'h080
`define PMU_CCAP_STRIDE    12'h004
// Offsets inside one counter's group of four words
`define PMU_SUB_CFG        2'h0
`define PMU_SUB_FLT        2'h1
`define PMU_SUB_VAL_LO     2'h2
`define PMU_SUB_VAL_HI     2'h3

// Sizes
`define PMU_NUM_CNT        4
`define PMU_NUM_CAT        6
`define PMU_EV_PER_CAT     8
`define PMU_CNT_W_WIDE     32
`define PMU_CNT_W_NARROW   16

// Event categories
`define PMU_CAT_WQ         4'h0
`define PMU_CAT_ENGINE     4'h1
`define PMU_CAT_XLATE      4'h2
`define PMU_CAT_OPS        4'h3
`define PMU_CAT_COMPL      4'h4
`define PMU_CAT_OPS2       4'h5

// Supported events per category
`define PMU_EVCAP_WQ       8'h0F
`define PMU_EVCAP_ENGINE   8'hFF
`define PMU_EVCAP_XLATE    8'h3F
`define PMU_EVCAP_OPS      8'hFF
`define PMU_EVCAP_COMPL    8'h07
`define PMU_EVCAP_OPS2     8'h00
`define PMU_CNT_CAT_MASK   8'h3F

// Global capability word fields
`define PMU_CAP_NUM_LSB    0
`define PMU_CAP_WIDTH_LSB  8
`define PMU_CAP_WWE_BIT    16
`define PMU_CAP_PCC_BIT    17
`define PMU_CAP_FLT_BIT    18
`define PMU_CAP_GFZ_BIT    19
`define PMU_CAP_INT_BIT    20

// Counter configuration fields
`define PMU_CFG_EN_BIT     0
`define PMU_CFG_GFZ_BIT    1
`define PMU_CFG_CAT_LSB    8
`define PMU_CFG_EV_LSB     16

// Filter configuration fields
`define PMU_FLT_WQ_LSB     0
`define PMU_FLT_TC_LSB     8

// Software reset control bits
`define PMU_RST_CFG_BIT    0
`define PMU_RST_CNT_BIT    1

// Reset values
`define PMU_CFG_RESET      32'h0000_0000
`define PMU_FLT_RESET      16'h0000
`define PMU_FRZ_RESET      4'h0
`define PMU_OVF_RESET      4'h0

`endif

// file: verilog/pmu_event_counter.v
// Event counter unit with APB register slave
//
// Decided for this implementation: register access over APB and the register addresses.
`include "pmu_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module pmu_event_counter #(
  parameter MON_PRESENT = 1,
  parameter WR_WHILE_EN = 1
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Event sources
  input  wire [47:0] ev_pulse,
  input  wire [2:0]  ev_wq,
  input  wire [2:0]  ev_tc
);

  localparam NC = `PMU_NUM_CNT;

  // Bus decode
  wire        setup_ph = psel & ~penable;
  wire        access   = psel & penable;
  wire        in_cnt   = (paddr >= `PMU_OFF_CNT_BASE) &&
                         (paddr < `PMU_OFF_CNT_BASE + NC * `PMU_CNT_STRIDE);
  wire        in_ccap  = (paddr >= `PMU_OFF_CCAP_BASE) &&
                         (paddr < `PMU_OFF_CCAP_BASE + NC * `PMU_CCAP_STRIDE);
  wire        in_evcap = (paddr >= `PMU_OFF_EVCAP) &&
                         (paddr < `PMU_OFF_EVCAP + `PMU_NUM_CAT * 4);
  wire [11:0] cnt_rel  = paddr - `PMU_OFF_CNT_BASE;
  wire [11:0] ccap_rel = paddr - `PMU_OFF_CCAP_BASE;
  wire [11:0] ev_rel   = paddr - `PMU_OFF_EVCAP;
  wire [1:0]  cnt_idx  = cnt_rel[5:4];
  wire [1:0]  cnt_sub  = cnt_rel[3:2];
  wire [1:0]  ccap_idx = ccap_rel[3:2];
  wire [3:0]  ev_idx   = ev_rel[5:2];
  wire        aligned  = (paddr[1:0] == 2'b00);
  wire        mapped   = aligned && ((MON_PRESENT == 0) ? (paddr == `PMU_OFF_CAP) :
                         ((paddr <= `PMU_OFF_FRZ) || in_cnt || in_ccap || in_evcap));
  // Unmapped writes have no effect, only the error answer
  wire        wr       = access & pwrite & mapped & (MON_PRESENT != 0);

  // Single-word register selects
  wire        sel_cap  = (paddr == `PMU_OFF_CAP);
  wire        sel_rst  = (paddr == `PMU_OFF_RST);
  wire        sel_ovf  = (paddr == `PMU_OFF_OVF);
  wire        sel_frz  = (paddr == `PMU_OFF_FRZ);

  // Zero wait states; unmapped access answers with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  wire wr_rst = wr && sel_rst;
  wire cfg_reset = wr_rst & pwdata[`PMU_RST_CFG_BIT];
  wire cnt_reset = wr_rst & pwdata[`PMU_RST_CNT_BIT];

  // Supported events per category, reserved ones report nothing
  function [7:0] ev_cap;
    input [3:0] cat;
    begin
      case (cat)
        `PMU_CAT_WQ:     ev_cap = `PMU_EVCAP_WQ;
        `PMU_CAT_ENGINE: ev_cap = `PMU_EVCAP_ENGINE;
        `PMU_CAT_XLATE:  ev_cap = `PMU_EVCAP_XLATE;
        `PMU_CAT_OPS:    ev_cap = `PMU_EVCAP_OPS;
        `PMU_CAT_COMPL:  ev_cap = `PMU_EVCAP_COMPL;
        `PMU_CAT_OPS2:   ev_cap = `PMU_EVCAP_OPS2;
        default:         ev_cap = 8'h00;
      endcase
    end
  endfunction

  function [3:0] popcount8;
    input [7:0] v;
    integer k;
    begin
      popcount8 = 4'h0;
      for (k = 0; k < 8; k = k + 1) begin
        popcount8 = popcount8 + {3'b000, v[k]};
      end
    end
  endfunction

  // Event capability table and supported pulses, one byte per category
  wire [`PMU_NUM_CAT*8-1:0] evcap_all;
  wire [`PMU_NUM_CAT*8-1:0] ev_sup_all;

  genvar ci;
  generate
    for (ci = 0; ci < `PMU_NUM_CAT; ci = ci + 1) begin : g_evcap
      localparam integer CI = ci;
      assign evcap_all[ci*8 +: 8]  = ev_cap(CI[3:0]);
      // Unsupported event bits never reach a counter
      assign ev_sup_all[ci*8 +: 8] = ev_pulse[ci*8 +: 8] & evcap_all[ci*8 +: 8];
    end
  endgenerate

  // Global state
  reg  [NC-1:0]    ovf_q;
  reg  [NC-1:0]    ovf_d;
  reg  [NC-1:0]    frz_q;
  reg  [NC-1:0]    frz_d;
  wire [NC-1:0]    ovf_ev;
  wire [NC-1:0]    gfz_ev;
  wire [NC*32-1:0] grp_all;
  wire [NC*16-1:0] ccap_all;

  genvar gi;
  generate
    for (gi = 0; gi < NC; gi = gi + 1) begin : g_cnt
      // Upper half of the counters is narrow
      localparam integer W = (gi < NC / 2) ? `PMU_CNT_W_WIDE : `PMU_CNT_W_NARROW;
      localparam [31:0] MASK = (W == 32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << W) - 32'h1);
      localparam integer GI = gi;

      reg  [31:0] cfg_q;
      reg  [31:0] cfg_d;
      reg  [15:0] flt_q;
      reg  [15:0] flt_d;
      reg  [31:0] cnt_q;
      reg  [31:0] cnt_d;
      reg  [31:0] grp_rd;

      wire        hit     = wr && in_cnt && (cnt_idx == GI[1:0]);
      wire        en      = cfg_q[`PMU_CFG_EN_BIT];
      wire [3:0]  cat     = cfg_q[`PMU_CFG_CAT_LSB +: 4];
      wire [7:0]  evm     = cfg_q[`PMU_CFG_EV_LSB +: 8];
      wire [7:0]  wq_m    = flt_q[`PMU_FLT_WQ_LSB +: 8];
      wire [7:0]  tc_m    = flt_q[`PMU_FLT_TC_LSB +: 8];
      wire [7:0]  raw     = (cat < `PMU_NUM_CAT) ? ev_sup_all[cat * 8 +: 8] : 8'h00;
      wire [7:0]  sel     = raw & evm;
      // Zero filter value means filter not applied
      wire        flt_ok  = ((wq_m == 8'h00) | wq_m[ev_wq]) &
                            ((tc_m == 8'h00) | tc_m[ev_tc]);
      wire [3:0]  inc     = flt_ok ? popcount8(sel) : 4'h0;
      wire        run     = en & ~frz_q[gi];
      // Carry out of the implemented width marks the wrap
      wire [32:0] sum     = {1'b0, cnt_q} + {29'd0, inc};
      wire        wrap    = sum[W];

      // Write strobes of this counter's registers
      wire        cfg_wr  = hit && (cnt_sub == `PMU_SUB_CFG);
      wire        flt_wr  = hit && (cnt_sub == `PMU_SUB_FLT);
      wire        val_wr  = hit && (cnt_sub == `PMU_SUB_VAL_LO) &&
                            (!en || WR_WHILE_EN != 0);

      assign ovf_ev[gi] = run && (inc != 4'h0) && wrap;
      assign gfz_ev[gi] = ovf_ev[gi] & cfg_q[`PMU_CFG_GFZ_BIT];
      assign grp_all[gi*32 +: 32]  = grp_rd;
      assign ccap_all[gi*16 +: 16] = {`PMU_CNT_CAT_MASK, W[7:0]};

      // Configuration: only the enable bit may change while enabled
      always @* begin
        cfg_d = cfg_q;
        flt_d = flt_q;
        if (cfg_wr && en) begin
          cfg_d[`PMU_CFG_EN_BIT] = pwdata[`PMU_CFG_EN_BIT];
        end else if (cfg_wr) begin
          cfg_d = pwdata;
        end
        if (flt_wr && !en) begin
          flt_d = pwdata[15:0];
        end
      end

      always @(posedge core_clk) begin
        if (rst || cfg_reset) begin
          cfg_q <= `PMU_CFG_RESET;
          flt_q <= `PMU_FLT_RESET;
        end else begin
          cfg_q <= cfg_d;
          flt_q <= flt_d;
        end
      end

      // Counter value: software write beats a same-cycle count
      always @* begin
        cnt_d = cnt_q;
        if (run) begin
          cnt_d = sum[31:0] & MASK;
        end
        if (val_wr) begin
          cnt_d = pwdata & MASK;
        end
      end

      always @(posedge core_clk) begin
        if (rst || cnt_reset) begin
          cnt_q <= 32'h0000_0000;
        end else begin
          cnt_q <= cnt_d;
        end
      end

      // Read word of this group; the high value word always reads zero
      always @* begin
        grp_rd = 32'h0000_0000;
        case (cnt_sub)
          `PMU_SUB_CFG:    grp_rd = cfg_q;
          `PMU_SUB_FLT:    grp_rd = {16'h0000, flt_q};
          `PMU_SUB_VAL_LO: grp_rd = cnt_q;
          default:         grp_rd = 32'h0000_0000;
        endcase
      end
    end
  endgenerate

  // Overflow flags: write one to clear, a new overflow wins
  wire wr_ovf = wr && sel_ovf;
  wire wr_frz = wr && sel_frz;

  always @* begin
    ovf_d = ovf_q;
    if (wr_ovf) begin
      ovf_d = ovf_q & ~pwdata[NC-1:0];
    end
    ovf_d = ovf_d | ovf_ev;
  end

  always @(posedge core_clk) begin
    if (rst || cnt_reset) begin
      ovf_q <= `PMU_OVF_RESET;
    end else begin
      ovf_q <= ovf_d;
    end
  end

  // Freeze: software sets or clears; global freeze on overflow wins
  always @* begin
    frz_d = frz_q;
    if (|gfz_ev) begin
      frz_d = {NC{1'b1}};
    end else if (wr_frz) begin
      frz_d = pwdata[NC-1:0];
    end
  end

  always @(posedge core_clk) begin
    if (rst || cfg_reset) begin
      frz_q <= `PMU_FRZ_RESET;
    end else begin
      frz_q <= frz_d;
    end
  end

  // Capability word, one field per line
  wire [31:0] cap_num   = NC << `PMU_CAP_NUM_LSB;
  wire [31:0] cap_width = `PMU_CNT_W_WIDE << `PMU_CAP_WIDTH_LSB;
  wire [31:0] cap_wwe   = (WR_WHILE_EN != 0 ? 1 : 0) << `PMU_CAP_WWE_BIT;
  wire [31:0] cap_pcc   = 1 << `PMU_CAP_PCC_BIT;
  wire [31:0] cap_flt   = 1 << `PMU_CAP_FLT_BIT;
  wire [31:0] cap_gfz   = 1 << `PMU_CAP_GFZ_BIT;
  // No interrupt output, so the capability is never claimed
  wire [31:0] cap_int   = 0 << `PMU_CAP_INT_BIT;
  wire [31:0] cap_word  = (MON_PRESENT == 0) ? 32'h0000_0000 :
                          (cap_num | cap_width | cap_wwe | cap_pcc | cap_flt | cap_gfz | cap_int);

  // Read data is captured in the setup cycle, held for the access cycle
  reg [31:0] rd_d;
  reg [31:0] prdata_d;
  always @* begin
    rd_d = 32'h0000_0000;
    if (sel_cap) begin
      rd_d = cap_word;
    end else if (MON_PRESENT == 0) begin
      rd_d = 32'h0000_0000;
    end else if (sel_ovf) begin
      rd_d = {{(32-NC){1'b0}}, ovf_q};
    end else if (sel_frz) begin
      rd_d = {{(32-NC){1'b0}}, frz_q};
    end else if (in_evcap) begin
      rd_d = {24'h00_0000, evcap_all[ev_idx*8 +: 8]};
    end else if (in_ccap) begin
      rd_d = {16'h0000, ccap_all[ccap_idx*16 +: 16]};
    end else if (in_cnt) begin
      rd_d = grp_all[cnt_idx*32 +: 32];
    end
  end

  // Unmapped reads return zero beside the error answer
  always @* begin
    prdata_d = prdata;
    if (setup_ph) begin
      prdata_d = mapped ? rd_d : 32'h0000_0000;
    end
  end

  // Held past the access cycle, so a slow master still sees it
  always @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= prdata_d;
    end
  end

endmodule // pmu_event_counter

`default_nettype wire
